// [ckp_consts.vh]
// Constants for the classifier key port and tag field builder
// Operation
// - Ingress mask selector is two bits, zero when no special case applies.
// - Frames arriving from a loopback device get selector one.
// - Masqueraded frames get selector two when masquerade mask enable is set.
// - Host injected, virtual port or loopback frames get three, each separately enabled.
// - Several matching criteria resolve to the highest selector value.
// - Bitmap is 53 bits: physical, looped-on or masqueraded port by selector.
// - Selector three packs source flags, source port, pipeline point and action.
// - Multicast flag is set when destination MAC bit 40 is one.
// - Broadcast flag is set for the all-ones destination MAC.
// - Outer tag protocol code: 0 none, 1, 4, and 5 to 7 custom.
// - Outer priority, drop bit, VLAN ID from frame, or classified when enabled.
// - Untagged frames force the outer VLAN ID field to zero.
// - Second tag protocol uses the same codes, zero when absent.
// - Third tag protocol uses the same codes, zero when absent.
// - Second tag priority, drop bit and VLAN ID copied straight from frame.
// - Third tag priority, drop bit and VLAN ID copied straight from frame.
// - Wide key type is two bits: full, normal, five-tuple, second custom.
// - Lookup order bit is set for first lookup, cleared for second.
`ifndef CKP_CONSTS_VH
`define CKP_CONSTS_VH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define CKP_REG_CTRL 6'h00
`define CKP_REG_CUST12 6'h04
`define CKP_REG_CUST3 6'h08
`define CKP_REG_STATUS 6'h0c

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define CKP_CTRL_MASQ 0
`define CKP_CTRL_HOST 1
`define CKP_CTRL_VPORT 2
`define CKP_CTRL_LBK3 3
`define CKP_CTRL_USECL 4
`define CKP_CTRL_W 5
`define CKP_CTRL_RST 5'h00
`define CKP_CUST1_RST 16'h0000
`define CKP_CUST2_RST 16'h0000
`define CKP_CUST3_RST 16'h0000

// ----------------------------------------------------------------
// Selector values and bitmap layout
// ----------------------------------------------------------------
`define CKP_SEL_DEFAULT 2'h0
`define CKP_SEL_LOOP 2'h1
`define CKP_SEL_MASQ 2'h2
`define CKP_SEL_SPECIAL 2'h3
`define CKP_MAP_W 53
`define CKP_MAP_SRC_LO 4
`define CKP_MAP_SRC_HI 9
`define CKP_MAP_PPT_LO 44
`define CKP_MAP_PPT_HI 48
`define CKP_MAP_PACT_LO 49
`define CKP_MAP_PACT_HI 51
`define CKP_MAP_RSVD 52
`define CKP_MC_BIT 40
`define CKP_BCAST_MAC 48'hffffffffffff

// ----------------------------------------------------------------
// Tag protocol values and codes
// ----------------------------------------------------------------
`define CKP_TPID_CTAG 16'h8100
`define CKP_TPID_STAG 16'h88a8
`define CKP_TC_NONE 3'h0
`define CKP_TC_CTAG 3'h1
`define CKP_TC_STAG 3'h4
`define CKP_TC_CUST1 3'h5
`define CKP_TC_CUST2 3'h6
`define CKP_TC_CUST3 3'h7

// ----------------------------------------------------------------
// Wide key types
// ----------------------------------------------------------------
`define CKP_KT_LL_FULL 2'h0
`define CKP_KT_NORMAL 2'h1
`define CKP_KT_FIVE_TUPLE 2'h2
`define CKP_KT_CUSTOM2 2'h3

`endif

// [ckp_tag_encode.v]
// Tag protocol identifier to key code encoder
`timescale 1ns/100ps
`include "ckp_consts.vh"
module ckp_tag_encode (
    tag_present,
    tag_tpid,
    custom1,
    custom2,
    custom3,
    tag_code
);
input wire tag_present;
input wire [15:0] tag_tpid;
input wire [15:0] custom1;
input wire [15:0] custom2;
input wire [15:0] custom3;
output reg [2:0] tag_code;

// Standard values win over an identical custom value
always @* begin
    tag_code = `CKP_TC_NONE;
    if (tag_present) begin
        if (tag_tpid == `CKP_TPID_CTAG) begin
            tag_code = `CKP_TC_CTAG;
        end else if (tag_tpid == `CKP_TPID_STAG) begin
            tag_code = `CKP_TC_STAG;
        end else if (tag_tpid == custom1) begin
            tag_code = `CKP_TC_CUST1;
        end else if (tag_tpid == custom2) begin
            tag_code = `CKP_TC_CUST2;
        end else if (tag_tpid == custom3) begin
            tag_code = `CKP_TC_CUST3;
        end
    end
end
endmodule // ckp_tag_encode

// [ckp_key_fields.v]
// Classifier wide key: ingress port mask and VLAN tag fields, AXI4-Lite config
`timescale 1ns/100ps
`include "ckp_consts.vh"
module ckp_key_fields #(
    parameter [5:0] HOST0_PORT = 6'h35,
    parameter [5:0] HOST1_PORT = 6'h36,
    parameter [5:0] VPORT0_PORT = 6'h37,
    parameter [5:0] VPORT1_PORT = 6'h38,
    parameter [2:0] MASQ_ACTION = 3'h1
) (
    mclk,
    reset,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    frame_valid,
    host_injected,
    src_port,
    phys_src_port,
    loopback_device,
    loop_port,
    pipeline_point,
    pipeline_action,
    dmac,
    tag_present,
    tag_tpid,
    tag_tci,
    cl_priority,
    cl_drop_eligible,
    cl_vlan_id,
    key_type_in,
    first_lookup,
    key_valid,
    wide_key_type,
    lookup_first_flag,
    ingress_mask_selector,
    ingress_port_bitmap,
    dest_multicast_flag,
    dest_broadcast_flag,
    outer_tag_protocol,
    outer_tag_priority,
    outer_tag_drop_eligible,
    outer_vlan_id,
    second_tag_protocol,
    second_tag_priority,
    second_tag_drop_eligible,
    second_vlan_id,
    third_tag_protocol,
    third_tag_priority,
    third_tag_drop_eligible,
    third_vlan_id
);
input wire mclk;
input wire reset;
input wire [5:0] s_axi_awaddr;
input wire s_axi_awvalid;
output wire s_axi_awready;
input wire [31:0] s_axi_wdata;
input wire [3:0] s_axi_wstrb;
input wire s_axi_wvalid;
output wire s_axi_wready;
output reg [1:0] s_axi_bresp;
output reg s_axi_bvalid;
input wire s_axi_bready;
input wire [5:0] s_axi_araddr;
input wire s_axi_arvalid;
output wire s_axi_arready;
output reg [31:0] s_axi_rdata;
output reg [1:0] s_axi_rresp;
output reg s_axi_rvalid;
input wire s_axi_rready;
input wire frame_valid;
input wire host_injected;
input wire [5:0] src_port;
input wire [5:0] phys_src_port;
input wire loopback_device;
input wire [5:0] loop_port;
input wire [4:0] pipeline_point;
input wire [2:0] pipeline_action;
input wire [47:0] dmac;
input wire [2:0] tag_present;
input wire [47:0] tag_tpid;
input wire [47:0] tag_tci;
input wire [2:0] cl_priority;
input wire cl_drop_eligible;
input wire [11:0] cl_vlan_id;
input wire [1:0] key_type_in;
input wire first_lookup;
output reg key_valid;
output reg [1:0] wide_key_type;
output reg lookup_first_flag;
output reg [1:0] ingress_mask_selector;
output reg [52:0] ingress_port_bitmap;
output reg dest_multicast_flag;
output reg dest_broadcast_flag;
output reg [2:0] outer_tag_protocol;
output reg [2:0] outer_tag_priority;
output reg outer_tag_drop_eligible;
output reg [11:0] outer_vlan_id;
output reg [2:0] second_tag_protocol;
output reg [2:0] second_tag_priority;
output reg second_tag_drop_eligible;
output reg [11:0] second_vlan_id;
output reg [2:0] third_tag_protocol;
output reg [2:0] third_tag_priority;
output reg third_tag_drop_eligible;
output reg [11:0] third_vlan_id;

// ----------------------------------------------------------------
// Configuration registers
// ----------------------------------------------------------------
reg [4:0] ctrl_r;
reg [15:0] cust1_r;
reg [15:0] cust2_r;
reg [15:0] cust3_r;
reg [15:0] key_count_r;
reg aw_held_r;
reg w_held_r;
reg [5:0] aw_addr_r;
reg [31:0] w_data_r;
reg [3:0] w_strb_r;
wire wr_fire;
wire [31:0] wmask;

assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
assign s_axi_wready = !w_held_r && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
assign wr_fire = aw_held_r && w_held_r;
assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

// Address and data are latched separately so either may come first
always @(posedge mclk or posedge reset) begin
    if (reset) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        aw_addr_r <= 6'h00;
        w_data_r <= 32'h00000000;
        w_strb_r <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
        ctrl_r <= `CKP_CTRL_RST;
        cust1_r <= `CKP_CUST1_RST;
        cust2_r <= `CKP_CUST2_RST;
        cust3_r <= `CKP_CUST3_RST;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            case ({aw_addr_r[5:2], 2'h0})
                `CKP_REG_CTRL: begin
                    ctrl_r <= (ctrl_r & ~wmask[4:0]) | (w_data_r[4:0] & wmask[4:0]);
                end
                `CKP_REG_CUST12: begin
                    cust1_r <= (cust1_r & ~wmask[15:0]) | (w_data_r[15:0] & wmask[15:0]);
                    cust2_r <= (cust2_r & ~wmask[31:16]) | (w_data_r[31:16] & wmask[31:16]);
                end
                `CKP_REG_CUST3: begin
                    cust3_r <= (cust3_r & ~wmask[15:0]) | (w_data_r[15:0] & wmask[15:0]);
                end
                `CKP_REG_STATUS: begin
                    s_axi_bresp <= 2'h0;
                end
                default: begin
                    s_axi_bresp <= 2'h2;
                end
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// Status: last selector and a wrapping count of built keys
always @(posedge mclk or posedge reset) begin
    if (reset) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case ({s_axi_araddr[5:2], 2'h0})
            `CKP_REG_CTRL: s_axi_rdata <= {27'h0, ctrl_r};
            `CKP_REG_CUST12: s_axi_rdata <= {cust2_r, cust1_r};
            `CKP_REG_CUST3: s_axi_rdata <= {16'h0000, cust3_r};
            `CKP_REG_STATUS: s_axi_rdata <= {key_count_r, 14'h0, ingress_mask_selector};
            default: begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= 2'h2;
            end
        endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Ingress mask selector and bitmap
// ----------------------------------------------------------------
function [52:0] port_onehot;
    input [5:0] port;
    begin
        // Ports beyond the mask width give an empty mask
        if (port < 6'h35) begin
            port_onehot = {52'h0000000000000, 1'b1} << port;
        end else begin
            port_onehot = 53'h0;
        end
    end
endfunction

wire is_masq;
wire is_vport;
wire sel3_hit;
reg [1:0] sel_nxt;
reg [52:0] map_nxt;

assign is_masq = (host_injected && (src_port != phys_src_port)) || (pipeline_action == MASQ_ACTION);
assign is_vport = (phys_src_port == VPORT0_PORT) || (phys_src_port == VPORT1_PORT);
assign sel3_hit = (host_injected && ctrl_r[`CKP_CTRL_HOST]) ||
    (is_vport && ctrl_r[`CKP_CTRL_VPORT]) ||
    (loopback_device && ctrl_r[`CKP_CTRL_LBK3]);

always @* begin
    sel_nxt = `CKP_SEL_DEFAULT;
    if (sel3_hit) begin
        sel_nxt = `CKP_SEL_SPECIAL;
    end else if (is_masq && ctrl_r[`CKP_CTRL_MASQ]) begin
        sel_nxt = `CKP_SEL_MASQ;
    end else if (loopback_device) begin
        sel_nxt = `CKP_SEL_LOOP;
    end
end

always @* begin
    map_nxt = 53'h0;
    case (sel_nxt)
        `CKP_SEL_DEFAULT: map_nxt = port_onehot(phys_src_port);
        `CKP_SEL_LOOP: map_nxt = port_onehot(loop_port);
        `CKP_SEL_MASQ: map_nxt = port_onehot(src_port);
        `CKP_SEL_SPECIAL: begin
            map_nxt[0] = (phys_src_port == HOST0_PORT);
            map_nxt[1] = (phys_src_port == HOST1_PORT);
            map_nxt[2] = (phys_src_port == VPORT0_PORT);
            map_nxt[3] = (phys_src_port == VPORT1_PORT);
            map_nxt[`CKP_MAP_SRC_HI:`CKP_MAP_SRC_LO] = src_port;
            map_nxt[`CKP_MAP_PPT_HI:`CKP_MAP_PPT_LO] = pipeline_point;
            map_nxt[`CKP_MAP_PACT_HI:`CKP_MAP_PACT_LO] = pipeline_action;
            map_nxt[`CKP_MAP_RSVD] = 1'b0;
        end
        default: map_nxt = 53'h0;
    endcase
end

// ----------------------------------------------------------------
// Tag protocol encoders
// ----------------------------------------------------------------
wire [8:0] tag_code;
genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_tag
        ckp_tag_encode u_enc (
            .tag_present(tag_present[gi]),
            .tag_tpid(tag_tpid[16*gi+15:16*gi]),
            .custom1(cust1_r),
            .custom2(cust2_r),
            .custom3(cust3_r),
            .tag_code(tag_code[3*gi+2:3*gi])
        );
    end
endgenerate

// ----------------------------------------------------------------
// Key output stage
// ----------------------------------------------------------------
// Fields update only with a frame so the engine sees a stable key
always @(posedge mclk or posedge reset) begin
    if (reset) begin
        key_valid <= 1'b0;
        key_count_r <= 16'h0000;
        wide_key_type <= `CKP_KT_LL_FULL;
        lookup_first_flag <= 1'b0;
        ingress_mask_selector <= `CKP_SEL_DEFAULT;
        ingress_port_bitmap <= 53'h0;
        dest_multicast_flag <= 1'b0;
        dest_broadcast_flag <= 1'b0;
        outer_tag_protocol <= `CKP_TC_NONE;
        outer_tag_priority <= 3'h0;
        outer_tag_drop_eligible <= 1'b0;
        outer_vlan_id <= 12'h000;
        second_tag_protocol <= `CKP_TC_NONE;
        second_tag_priority <= 3'h0;
        second_tag_drop_eligible <= 1'b0;
        second_vlan_id <= 12'h000;
        third_tag_protocol <= `CKP_TC_NONE;
        third_tag_priority <= 3'h0;
        third_tag_drop_eligible <= 1'b0;
        third_vlan_id <= 12'h000;
    end else begin
        key_valid <= frame_valid;
        if (frame_valid) begin
            key_count_r <= key_count_r + 16'h0001;
            wide_key_type <= key_type_in;
            lookup_first_flag <= first_lookup;
            ingress_mask_selector <= sel_nxt;
            ingress_port_bitmap <= map_nxt;
            dest_multicast_flag <= dmac[`CKP_MC_BIT];
            dest_broadcast_flag <= (dmac == `CKP_BCAST_MAC);
            outer_tag_protocol <= tag_code[2:0];
            if (ctrl_r[`CKP_CTRL_USECL]) begin
                outer_tag_priority <= cl_priority;
                outer_tag_drop_eligible <= cl_drop_eligible;
                outer_vlan_id <= cl_vlan_id;
            end else begin
                outer_tag_priority <= tag_tci[15:13];
                outer_tag_drop_eligible <= tag_tci[12];
                outer_vlan_id <= tag_tci[11:0];
            end
            if (!tag_present[0]) begin
                outer_vlan_id <= 12'h000;
            end
            second_tag_protocol <= tag_code[5:3];
            second_tag_priority <= tag_tci[31:29];
            second_tag_drop_eligible <= tag_tci[28];
            second_vlan_id <= tag_tci[27:16];
            third_tag_protocol <= tag_code[8:6];
            third_tag_priority <= tag_tci[47:45];
            third_tag_drop_eligible <= tag_tci[44];
            third_vlan_id <= tag_tci[43:32];
        end
    end
end
endmodule // ckp_key_fields

// [ckp_key_fields_properties.sv]
// Concurrent checks on the key field builder ports
`timescale 1ns/100ps
module ckp_key_fields_properties (
    input wire mclk,
    input wire reset,
    input wire frame_valid,
    input wire loopback_device,
    input wire [47:0] dmac,
    input wire [2:0] tag_present,
    input wire [1:0] key_type_in,
    input wire first_lookup,
    input wire key_valid,
    input wire [1:0] wide_key_type,
    input wire lookup_first_flag,
    input wire [1:0] ingress_mask_selector,
    input wire dest_multicast_flag,
    input wire dest_broadcast_flag,
    input wire [2:0] outer_tag_protocol,
    input wire [11:0] outer_vlan_id,
    input wire [2:0] second_tag_protocol,
    input wire [2:0] third_tag_protocol
);
// ----------------------------------------------------------------
// Key timing and field relations
// ----------------------------------------------------------------
default clocking cb @(posedge mclk);
endclocking
default disable iff (reset);

sequence s_lone_frame;
    !frame_valid ##1 frame_valid ##1 !frame_valid;
endsequence
sequence s_key_pulse;
    key_valid ##1 !key_valid;
endsequence

a_key_once: assert property (s_lone_frame |-> s_key_pulse)
    else $error("key valid is not a single pulse after a lone frame");
a_first_order: assert property (frame_valid |=> lookup_first_flag == $past(first_lookup))
    else $error("lookup order bit differs from request");
a_type_copy: assert property (frame_valid |=> wide_key_type == $past(key_type_in))
    else $error("wide key type differs from request");
a_mc_flag: assert property (frame_valid |=> dest_multicast_flag == $past(dmac[40]))
    else $error("multicast flag does not follow address bit 40");
a_bc_flag: assert property (frame_valid |=> dest_broadcast_flag == ($past(dmac) == 48'hffffffffffff))
    else $error("broadcast flag does not match all-ones address");
a_untagged_vid: assert property (frame_valid && !tag_present[0] |=>
    outer_vlan_id == 12'h000 && outer_tag_protocol == 3'h0)
    else $error("untagged frame gave nonzero outer fields");
a_second_absent: assert property (frame_valid && !tag_present[1] |=> second_tag_protocol == 3'h0)
    else $error("absent second tag gave nonzero code");
a_third_absent: assert property (frame_valid && !tag_present[2] |=> third_tag_protocol == 3'h0)
    else $error("absent third tag gave nonzero code");
a_no_code23: assert property (key_valid |-> outer_tag_protocol[2:1] != 2'h1 &&
    second_tag_protocol[2:1] != 2'h1 && third_tag_protocol[2:1] != 2'h1)
    else $error("unassigned tag protocol code produced");
a_loop_floor: assert property (frame_valid && loopback_device |=> ingress_mask_selector != 2'h0)
    else $error("loopback frame left selector at zero");
a_sel_held: assert property (s_lone_frame ##1 !frame_valid |-> $stable(ingress_mask_selector))
    else $error("selector changed without a frame");
endmodule // ckp_key_fields_properties

bind ckp_key_fields ckp_key_fields_properties i_ckp_key_fields_properties (
    .mclk(mclk), .reset(reset), .frame_valid(frame_valid), .loopback_device(loopback_device),
    .dmac(dmac), .tag_present(tag_present), .key_type_in(key_type_in), .first_lookup(first_lookup),
    .key_valid(key_valid), .wide_key_type(wide_key_type), .lookup_first_flag(lookup_first_flag),
    .ingress_mask_selector(ingress_mask_selector), .dest_multicast_flag(dest_multicast_flag),
    .dest_broadcast_flag(dest_broadcast_flag), .outer_tag_protocol(outer_tag_protocol),
    .outer_vlan_id(outer_vlan_id), .second_tag_protocol(second_tag_protocol),
    .third_tag_protocol(third_tag_protocol)
);

// [ckp_lookup_model.sv]
// Far-side lookup engine stand-in that takes every key it is offered
`timescale 1ns/100ps
module ckp_lookup_model (
    input wire mclk,
    input wire reset,
    input wire key_valid,
    output reg [15:0] keys_seen
);
// Key stands one cycle only, so it is taken on that edge or lost
always @(posedge mclk or posedge reset) begin
    if (reset)
        keys_seen <= 16'h0000;
    else if (key_valid)
        keys_seen <= keys_seen + 16'h0001;
end
endmodule // ckp_lookup_model

// [ckp_key_fields_test.sv]
// Self-checking bench for the classifier key field builder
`timescale 1ns/100ps
module ckp_key_fields_test;
localparam [5:0] H0 = 6'h35;
localparam [5:0] V1 = 6'h38;
localparam [2:0] MA = 3'h1;
reg mclk = 1'h0;
reg reset = 1'h1;
reg [5:0] s_axi_awaddr = 6'h00;
reg [5:0] s_axi_araddr = 6'h00;
reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1, s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
reg [31:0] s_axi_wdata = 32'h0;
reg [3:0] s_axi_wstrb = 4'hf;
reg frame_valid = 1'h0, host_injected = 1'h0, loopback_device = 1'h0, first_lookup = 1'h0;
reg cl_drop_eligible = 1'h1;
reg [5:0] src_port = 6'h05, phys_src_port = 6'h05, loop_port = 6'h09;
reg [4:0] pipeline_point = 5'h11;
reg [2:0] pipeline_action = 3'h0, tag_present = 3'h0, cl_priority = 3'h6;
reg [47:0] dmac = 48'h0, tag_tpid = 48'h0, tag_tci = 48'h6abcb4562789;
reg [11:0] cl_vlan_id = 12'h5a5;
reg [1:0] key_type_in = 2'h0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, key_valid;
wire [1:0] s_axi_bresp, s_axi_rresp, wide_key_type, ingress_mask_selector;
wire [31:0] s_axi_rdata;
wire [52:0] ingress_port_bitmap;
wire lookup_first_flag, dest_multicast_flag, dest_broadcast_flag;
wire outer_tag_drop_eligible, second_tag_drop_eligible, third_tag_drop_eligible;
wire [2:0] outer_tag_protocol, outer_tag_priority, second_tag_protocol, second_tag_priority;
wire [2:0] third_tag_protocol, third_tag_priority;
wire [11:0] outer_vlan_id, second_vlan_id, third_vlan_id;
wire [15:0] keys_seen;
integer miscompares = 0;
integer cmp_count = 0;
integer i;
reg [15:0] nk = 16'h0;

ckp_key_fields #(.HOST0_PORT(H0), .VPORT1_PORT(V1), .MASQ_ACTION(MA)) i_ckp_key_fields (
    .mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .frame_valid, .host_injected, .src_port, .phys_src_port, .loopback_device, .loop_port,
    .pipeline_point, .pipeline_action, .dmac, .tag_present, .tag_tpid, .tag_tci, .cl_priority,
    .cl_drop_eligible, .cl_vlan_id, .key_type_in, .first_lookup, .key_valid, .wide_key_type,
    .lookup_first_flag, .ingress_mask_selector, .ingress_port_bitmap, .dest_multicast_flag,
    .dest_broadcast_flag, .outer_tag_protocol, .outer_tag_priority, .outer_tag_drop_eligible,
    .outer_vlan_id, .second_tag_protocol, .second_tag_priority, .second_tag_drop_eligible,
    .second_vlan_id, .third_tag_protocol, .third_tag_priority, .third_tag_drop_eligible, .third_vlan_id
);
ckp_lookup_model i_ckp_lookup_model (.mclk, .reset, .key_valid, .keys_seen);

always #25 mclk = ~mclk;

// ----------------------------------------------------------------
// Access tasks
// ----------------------------------------------------------------
task chk(input string nm, input [63:0] e, input [63:0] g);
    begin
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("wrong value %s: expected %h seen %h", nm, e, g);
        end
    end
endtask

task end_of_test;
    begin
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
endtask

task timed_out;
    begin
        miscompares = miscompares + 1;
        $display("wrong value handshake: expected answer seen none");
        end_of_test;
    end
endtask

task axi_wr(input [5:0] a, input [31:0] d, input [1:0] er);
    integer n;
    begin
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        for (n = 0; n < 50; n = n + 1) begin
            @(posedge mclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
                chk("write response", er, s_axi_bresp);
                n = 99;
            end
        end
        if (n < 99)
            timed_out;
    end
endtask

task axi_rd(input [5:0] a, input [31:0] e, input [1:0] er);
    integer n;
    begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        for (n = 0; n < 50; n = n + 1) begin
            @(posedge mclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
                chk("read data", e, s_axi_rdata);
                chk("read response", er, s_axi_rresp);
                n = 99;
            end
        end
        if (n < 99)
            timed_out;
    end
endtask

// Called at an edge; key is looked at in its one valid cycle
task frame(input [1:0] es, input [52:0] em);
    begin
        frame_valid <= 1'h1;
        @(posedge mclk);
        frame_valid <= 1'h0;
        nk = nk + 16'h1;
        #1;
        chk("key valid", 1, key_valid);
        chk("mask selector", es, ingress_mask_selector);
        chk("port bitmap", em, ingress_port_bitmap);
        @(posedge mclk);
    end
endtask

task tag_case(input [2:0] t, input [47:0] id, input [8:0] ec);
    begin
        tag_present <= t;
        tag_tpid <= id;
        frame(2'h0, 53'h20);
        chk("tag codes", ec, {third_tag_protocol, second_tag_protocol, outer_tag_protocol});
        chk("outer tci", t[0] ? tag_tci[15:0] : {tag_tci[15:12], 12'h0},
            {outer_tag_priority, outer_tag_drop_eligible, outer_vlan_id});
        chk("second tci", tag_tci[31:16], {second_tag_priority, second_tag_drop_eligible, second_vlan_id});
        chk("third tci", tag_tci[47:32], {third_tag_priority, third_tag_drop_eligible, third_vlan_id});
    end
endtask

// ----------------------------------------------------------------
// Test sequence
// ----------------------------------------------------------------
initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'h0;
    @(posedge mclk);
    axi_rd(6'h00, 32'h0, 2'h0);
    axi_rd(6'h04, 32'h0, 2'h0);
    axi_rd(6'h10, 32'h0, 2'h2);
    axi_wr(6'h14, 32'h1f, 2'h2);
    axi_wr(6'h0c, 32'hffffffff, 2'h0);
    axi_rd(6'h00, 32'h0, 2'h0);
    frame(2'h0, 53'h20);
    loopback_device <= 1'h1;
    frame(2'h1, 53'h200);
    loopback_device <= 1'h0;
    host_injected <= 1'h1;
    src_port <= 6'h07;
    frame(2'h0, 53'h20);
    axi_wr(6'h00, 32'h1, 2'h0);
    frame(2'h2, 53'h80);
    host_injected <= 1'h0;
    pipeline_action <= MA;
    frame(2'h2, 53'h80);
    loopback_device <= 1'h1;
    frame(2'h2, 53'h80);
    axi_wr(6'h00, 32'h9, 2'h0);
    frame(2'h3, {1'h0, 3'h1, 5'h11, 34'h0, 6'h07, 4'h0});
    loopback_device <= 1'h0;
    pipeline_action <= 3'h0;
    host_injected <= 1'h1;
    phys_src_port <= H0;
    axi_wr(6'h00, 32'h2, 2'h0);
    frame(2'h3, {1'h0, 3'h0, 5'h11, 34'h0, 6'h07, 4'h1});
    host_injected <= 1'h0;
    phys_src_port <= V1;
    frame(2'h0, 53'h0);
    axi_wr(6'h00, 32'h4, 2'h0);
    frame(2'h3, {1'h0, 3'h0, 5'h11, 34'h0, 6'h07, 4'h8});
    axi_rd(6'h00, 32'h4, 2'h0);
    axi_wr(6'h00, 32'h0, 2'h0);
    phys_src_port <= 6'h05;
    for (i = 0; i < 4; i = i + 1) begin
        dmac <= (i == 0) ? 48'h010000000000 : (i == 1) ? 48'hffffffffffff : (i == 2) ? 48'hfffffffffffe : 48'hfeffffffffff;
        key_type_in <= i[1:0];
        first_lookup <= i[0];
        frame(2'h0, 53'h20);
        chk("multicast flag", i != 3, dest_multicast_flag);
        chk("broadcast flag", i == 1, dest_broadcast_flag);
        chk("key type", i[1:0], wide_key_type);
        chk("first flag", i[0], lookup_first_flag);
    end
    axi_wr(6'h04, 32'h92009100, 2'h0);
    axi_wr(6'h08, 32'h00009300, 2'h0);
    axi_rd(6'h04, 32'h92009100, 2'h0);
    tag_case(3'h7, 48'h930088a88100, 9'o741);
    tag_case(3'h7, 48'h910092009100, 9'o565);
    tag_case(3'h1, 48'h810081009200, 9'o006);
    tag_case(3'h7, 48'h810088a81234, 9'o140);
    tag_case(3'h0, 48'h810081008100, 9'o000);
    axi_wr(6'h00, 32'h10, 2'h0);
    tag_present <= 3'h1;
    frame(2'h0, 53'h20);
    chk("classified tci", {3'h6, 1'h1, 12'h5a5}, {outer_tag_priority, outer_tag_drop_eligible, outer_vlan_id});
    chk("second tci", tag_tci[31:16], {second_tag_priority, second_tag_drop_eligible, second_vlan_id});
    tag_present <= 3'h0;
    frame(2'h0, 53'h20);
    chk("untagged vid", 12'h000, outer_vlan_id);
    axi_rd(6'h0c, {nk, 16'h0000}, 2'h0);
    chk("keys seen", nk, keys_seen);
    end_of_test;
end
endmodule // ckp_key_fields_test
